// ==== core/ulsf_core.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ulsf_core
	import ulsf_pkg::*;
(
	// clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// axi4-lite write channels
	input  wire logic                   awvalid,
	output var  logic                   awready,
	input  wire logic [ULSF_ADDR_W-1:0] awaddr,
	input  wire logic                   wvalid,
	output var  logic                   wready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	output var  logic                   bvalid,
	input  wire logic                   bready,
	output var  logic [1:0]             bresp,
	// axi4-lite read channels
	input  wire logic                   arvalid,
	output var  logic                   arready,
	input  wire logic [ULSF_ADDR_W-1:0] araddr,
	output var  logic                   rvalid,
	input  wire logic                   rready,
	output var  logic [31:0]            rdata,
	output var  logic [1:0]             rresp,
	// receiver frame
	input  wire logic                   rx_done,
	input  wire logic [7:0]             rx_data,
	input  wire logic                   rx_par_bit,
	input  wire logic                   rx_stop_bit,
	input  wire logic                   rx_line,
	// transmitter shifter
	input  wire logic                   tx_take,
	input  wire logic                   tx_shift_busy,
	output var  logic                   tx_avail,
	output var  logic [7:0]             tx_data,
	// interrupt
	output var  logic                   irq
);

	// =========================================================
	// address decode
	function automatic logic ulsf_hit(input logic [3:0] a, input logic [3:0] off);
		ulsf_hit = (a == off);
	endfunction

	function automatic logic ulsf_mapped(input logic [3:0] a);
		ulsf_mapped = ulsf_hit(a, ULSF_OFF_DATA) | ulsf_hit(a, ULSF_OFF_STAT)
		            | ulsf_hit(a, ULSF_OFF_CTRL) | ulsf_hit(a, ULSF_OFF_LEVEL);
	endfunction

	// =========================================================
	// state
	logic                awready_reg;
	logic                wready_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                arready_reg;
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic [3:0]          aw_addr_reg;
	logic [7:0]          w_data_reg;
	logic                w_lane0_reg;
	logic [ULSF_CTL_W-1:0] ctrl_reg;
	logic [7:0]          tx_mem [ULSF_DEPTH];
	logic [ULSF_PTR_W-1:0] tx_rd_reg;
	logic [ULSF_PTR_W-1:0] tx_wr_reg;
	logic [4:0]          tx_cnt_reg;
	logic                tx_avail_reg;
	logic [7:0]          tx_data_reg;
	logic                thre_reg;
	logic                temt_reg;
	logic                irq_reg;
	logic [10:0]         rx_mem [ULSF_DEPTH];
	logic [ULSF_PTR_W-1:0] rx_rd_reg;
	logic [ULSF_PTR_W-1:0] rx_wr_reg;
	logic [4:0]          rx_cnt_reg;
	logic [2:0]          err_reg;
	logic                ovr_reg;
	logic                brk_hold_reg;

	// =========================================================
	// character checker
	ulsf_chk_if chk_bus ();

	assign chk_bus.done     = rx_done;
	assign chk_bus.data     = rx_data;
	assign chk_bus.par_bit  = rx_par_bit;
	assign chk_bus.stop_bit = rx_stop_bit;
	assign chk_bus.par_en   = ctrl_reg[ULSF_CTL_PAR_EN];
	assign chk_bus.par_even = ctrl_reg[ULSF_CTL_PAR_EVEN];
	assign chk_bus.wlen     = ctrl_reg[ULSF_CTL_WLEN_LO +: 2];

	ulsf_rx_check u_check (
		.aclk    (aclk),
		.aresetn (aresetn),
		.chk     (chk_bus.chk_side)
	);

	// =========================================================
	// bus handshakes
	wire logic       wr_exec  = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire logic       wr_map   = ulsf_mapped(aw_addr_reg);
	wire logic       wr_data  = wr_exec & ulsf_hit(aw_addr_reg, ULSF_OFF_DATA) & w_lane0_reg;
	wire logic       wr_ctrl  = wr_exec & ulsf_hit(aw_addr_reg, ULSF_OFF_CTRL) & w_lane0_reg;
	wire logic       b_done   = bvalid_reg & bready;
	wire logic       rd_exec  = arvalid & arready_reg;
	wire logic       r_done   = rvalid_reg & rready;
	wire logic       rd_data  = rd_exec & ulsf_hit(araddr, ULSF_OFF_DATA);
	wire logic       rd_stat  = rd_exec & ulsf_hit(araddr, ULSF_OFF_STAT);

	// a mode change empties both fifos, as the old contents mean nothing
	wire logic       fifo_en  = ctrl_reg[ULSF_CTL_FIFO_EN];
	wire logic       flush    = wr_ctrl & (w_data_reg[ULSF_CTL_FIFO_EN] != fifo_en);
	wire logic [4:0] limit    = fifo_en ? ULSF_LIM_FIFO : ULSF_LIM_HOLD;

	// =========================================================
	// transmit side: holding register is a fifo of depth one
	wire logic       tx_push  = wr_data & (tx_cnt_reg < limit);
	wire logic       tx_pop   = tx_take & (tx_cnt_reg != 5'h00);
	wire logic [4:0] tx_cnt_n = flush ? 5'h00
	                          : 5'(tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_pop});
	wire logic [ULSF_PTR_W-1:0] tx_rd_n = flush ? '0
	                          : ULSF_PTR_W'(tx_rd_reg + {3'h0, tx_pop});
	wire logic [ULSF_PTR_W-1:0] tx_wr_n = flush ? '0
	                          : ULSF_PTR_W'(tx_wr_reg + {3'h0, tx_push});
	// bypass when the written byte is the new head
	wire logic [7:0] tx_head_n = (tx_push & (tx_rd_n == tx_wr_reg)) ? w_data_reg
	                           : tx_mem[tx_rd_n];
	wire logic       thre_n   = (tx_cnt_n == 5'h00);
	// a take in flight counts as busy until the shifter reports it
	wire logic       temt_n   = thre_n & ~tx_shift_busy & ~tx_take;

	// =========================================================
	// receive side
	wire logic       is_brk   = chk_bus.chk_tags[ULSF_TAG_BI];
	wire logic       rx_new   = chk_bus.chk_valid & ~(is_brk & brk_hold_reg);
	wire logic       rx_full  = (rx_cnt_reg >= limit);
	wire logic       rx_push  = rx_new & ~rx_full & ~flush;
	wire logic       rx_ovr   = rx_new & rx_full;
	wire logic       rx_pop   = rd_data & (rx_cnt_reg != 5'h00);
	wire logic [4:0] rx_cnt_n = flush ? 5'h00
	                          : 5'(rx_cnt_reg + {4'h0, rx_push} - {4'h0, rx_pop});
	wire logic [ULSF_PTR_W-1:0] rx_rd_n = flush ? '0
	                          : ULSF_PTR_W'(rx_rd_reg + {3'h0, rx_pop});
	wire logic [ULSF_PTR_W-1:0] rx_wr_n = flush ? '0
	                          : ULSF_PTR_W'(rx_wr_reg + {3'h0, rx_push});
	wire logic [10:0] rx_in   = {chk_bus.chk_tags, chk_bus.chk_data};
	wire logic [10:0] rx_head = rx_mem[rx_rd_reg];

	// the flags follow whichever character has just become the head
	wire logic       head_in  = rx_push & ((rx_cnt_reg == 5'h00)
	                          | ((rx_cnt_reg == 5'h01) & rx_pop));
	wire logic       head_adv = rx_pop & (rx_cnt_reg > 5'h01);
	wire logic [2:0] head_tag = head_in  ? rx_in[10:8]
	                          : head_adv ? rx_mem[rx_rd_n][10:8]
	                          : ULSF_TAGS_NONE;
	// set wins over the read that clears
	wire logic [2:0] err_n    = (rd_stat ? ULSF_TAGS_NONE : err_reg) | head_tag;
	wire logic       ovr_n    = (ovr_reg & ~rd_stat) | rx_ovr;
	// hold off further break characters until the line goes idle again
	wire logic       brk_n    = (chk_bus.chk_valid & is_brk) | (brk_hold_reg & ~rx_line);

	// =========================================================
	// read data selection
	wire logic [7:0] stat_val = {1'b0, temt_reg, thre_reg, err_reg, ovr_reg,
	                             (rx_cnt_reg != 5'h00)};
	wire logic [31:0] rd_val  =
		ulsf_hit(araddr, ULSF_OFF_DATA)  ? {24'h0, rx_head[7:0]} :
		ulsf_hit(araddr, ULSF_OFF_STAT)  ? {24'h0, stat_val} :
		ulsf_hit(araddr, ULSF_OFF_CTRL)  ? {26'h0, ctrl_reg} :
		ulsf_hit(araddr, ULSF_OFF_LEVEL) ? {19'h0, rx_cnt_reg, 3'h0, tx_cnt_reg} :
		32'h0;

	// =========================================================
	// write address and data capture, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_addr_reg <= 4'h0;
			w_data_reg  <= 8'h00;
			w_lane0_reg <= 1'b0;
		end
		else
		begin
			if (awvalid & awready_reg)
			begin
				awready_reg <= 1'b0;
				aw_addr_reg <= awaddr;
			end
			else if (b_done)
				awready_reg <= 1'b1;
			if (wvalid & wready_reg)
			begin
				wready_reg  <= 1'b0;
				w_data_reg  <= wdata[7:0];
				w_lane0_reg <= wstrb[0];
			end
			else if (b_done)
				wready_reg <= 1'b1;
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= ULSF_RESP_OKAY;
		end
		else if (wr_exec)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_map ? ULSF_RESP_OKAY : ULSF_RESP_SLV;
		end
		else if (b_done)
			bvalid_reg <= 1'b0;
	end

	// read response, one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= ULSF_RESP_OKAY;
		end
		else if (rd_exec)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_val;
			rresp_reg   <= ulsf_mapped(araddr) ? ULSF_RESP_OKAY : ULSF_RESP_SLV;
		end
		else if (r_done)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	// =========================================================
	// control register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_reg <= ULSF_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_reg <= w_data_reg[ULSF_CTL_W-1:0];
	end

	// =========================================================
	// fifo storage, entries written by index
	genvar gi;
	generate
		for (gi = 0; gi < ULSF_DEPTH; gi++)
		begin : g_mem
			always_ff @(posedge aclk)
			begin
				if (tx_push & (tx_wr_reg == ULSF_PTR_W'(gi)))
					tx_mem[gi] <= w_data_reg;
				if (rx_push & (rx_wr_reg == ULSF_PTR_W'(gi)))
					rx_mem[gi] <= rx_in;
			end
		end
	endgenerate

	// =========================================================
	// transmit pointers and flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_rd_reg    <= '0;
			tx_wr_reg    <= '0;
			tx_cnt_reg   <= 5'h00;
			tx_avail_reg <= 1'b0;
			tx_data_reg  <= 8'h00;
			thre_reg     <= 1'b1;
			temt_reg     <= 1'b1;
			irq_reg      <= 1'b0;
		end
		else
		begin
			tx_rd_reg    <= tx_rd_n;
			tx_wr_reg    <= tx_wr_n;
			tx_cnt_reg   <= tx_cnt_n;
			tx_avail_reg <= ~thre_n;
			tx_data_reg  <= tx_head_n;
			thre_reg     <= thre_n;
			temt_reg     <= temt_n;
			irq_reg      <= thre_n & ctrl_reg[ULSF_CTL_THRI_EN];
		end
	end

	// =========================================================
	// receive pointers and flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_rd_reg    <= '0;
			rx_wr_reg    <= '0;
			rx_cnt_reg   <= 5'h00;
			err_reg      <= ULSF_TAGS_NONE;
			ovr_reg      <= 1'b0;
			brk_hold_reg <= 1'b0;
		end
		else
		begin
			rx_rd_reg    <= rx_rd_n;
			rx_wr_reg    <= rx_wr_n;
			rx_cnt_reg   <= rx_cnt_n;
			err_reg      <= err_n;
			ovr_reg      <= ovr_n;
			brk_hold_reg <= brk_n;
		end
	end

	// =========================================================
	// outputs, all from flops
	assign awready  = awready_reg;
	assign wready   = wready_reg;
	assign bvalid   = bvalid_reg;
	assign bresp    = bresp_reg;
	assign arready  = arready_reg;
	assign rvalid   = rvalid_reg;
	assign rdata    = rdata_reg;
	assign rresp    = rresp_reg;
	assign tx_avail = tx_avail_reg;
	assign tx_data  = tx_data_reg;
	assign irq      = irq_reg;

endmodule

`default_nettype wire

// ==== include/ulsf_pkg.sv ====
`default_nettype none

package ulsf_pkg;

	// =========================================================
	// register map (byte addresses)
	localparam int          ULSF_ADDR_W    = 4;
	localparam logic [3:0]  ULSF_OFF_DATA  = 4'h0;
	localparam logic [3:0]  ULSF_OFF_STAT  = 4'h4;
	localparam logic [3:0]  ULSF_OFF_CTRL  = 4'h8;
	localparam logic [3:0]  ULSF_OFF_LEVEL = 4'hc;

	// =========================================================
	// control register fields
	localparam int          ULSF_CTL_FIFO_EN  = 0;
	localparam int          ULSF_CTL_THRI_EN  = 1;
	localparam int          ULSF_CTL_PAR_EN   = 2;
	localparam int          ULSF_CTL_PAR_EVEN = 3;
	localparam int          ULSF_CTL_WLEN_LO  = 4;
	localparam int          ULSF_CTL_W        = 6;
	localparam logic [5:0]  ULSF_CTRL_RESET   = 6'h00;

	// =========================================================
	// line status fields
	localparam int          ULSF_STAT_DR   = 0;
	localparam int          ULSF_STAT_OE   = 1;
	localparam int          ULSF_STAT_PE   = 2;
	localparam int          ULSF_STAT_FE   = 3;
	localparam int          ULSF_STAT_BI   = 4;
	localparam int          ULSF_STAT_THRE = 5;
	localparam int          ULSF_STAT_TEMT = 6;

	// =========================================================
	// per-character error tags, same order as line status bits 2..4
	localparam int          ULSF_TAG_PE    = 0;
	localparam int          ULSF_TAG_FE    = 1;
	localparam int          ULSF_TAG_BI    = 2;
	localparam logic [2:0]  ULSF_TAGS_NONE = 3'h0;

	// =========================================================
	// fifo geometry
	localparam int          ULSF_PTR_W     = 4;
	localparam int          ULSF_DEPTH     = 16;
	localparam logic [4:0]  ULSF_LIM_FIFO  = 5'h10;
	localparam logic [4:0]  ULSF_LIM_HOLD  = 5'h01;

	// =========================================================
	// bus responses
	localparam logic [1:0]  ULSF_RESP_OKAY = 2'h0;
	localparam logic [1:0]  ULSF_RESP_SLV  = 2'h2;

endpackage

`default_nettype wire

// ==== include/ulsf_chk_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// raw receiver frame in, classified character out
interface ulsf_chk_if;
	logic       done;
	logic [7:0] data;
	logic       par_bit;
	logic       stop_bit;
	logic       par_en;
	logic       par_even;
	logic [1:0] wlen;
	logic       chk_valid;
	logic [7:0] chk_data;
	logic [2:0] chk_tags;

	modport chk_side (
		input  done, data, par_bit, stop_bit, par_en, par_even, wlen,
		output chk_valid, chk_data, chk_tags
	);
	modport core_side (
		output done, data, par_bit, stop_bit, par_en, par_even, wlen,
		input  chk_valid, chk_data, chk_tags
	);
endinterface

`default_nettype wire

// ==== core/ulsf_rx_check.sv ====
`timescale 1ns/1ps
`default_nettype none

module ulsf_rx_check
	import ulsf_pkg::*;
(
	// clock and reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// frame in, tags out
	ulsf_chk_if.chk_side      chk
);

	// =========================================================
	// word length mask, 5 to 8 bits
	function automatic logic [7:0] ulsf_mask(input logic [1:0] wl);
		ulsf_mask = 8'hff >> (2'h3 - wl);
	endfunction

	wire logic [7:0] data_m   = chk.data & ulsf_mask(chk.wlen);
	wire logic       par_odd  = ^data_m ^ chk.par_bit;
	// even setting wants an even count of ones, odd wants odd
	wire logic       pe_hit   = chk.par_en & (par_odd ^ ~chk.par_even);
	wire logic       fe_hit   = ~chk.stop_bit;
	// line low through data, parity and stop: a whole frame of zeros
	wire logic       bi_hit   = (data_m == 8'h00) & ~chk.stop_bit
	                          & (~chk.par_en | ~chk.par_bit);

	// =========================================================
	// one-cycle registered classification
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			chk.chk_valid <= 1'b0;
			chk.chk_data  <= 8'h00;
			chk.chk_tags  <= ULSF_TAGS_NONE;
		end
		else
		begin
			chk.chk_valid <= chk.done;
			chk.chk_data  <= data_m;
			chk.chk_tags  <= {bi_hit, fe_hit, pe_hit & ~bi_hit};
		end
	end

endmodule

`default_nettype wire

// ==== verification/ulsf_tx_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// transmit shifter model: takes a waiting character, then stays busy
module ulsf_tx_sink
#(
	parameter int HOLD = 12
)
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// bench control, low stalls the shifter
	input  wire logic       go,
	// holding side of the block
	input  wire logic       tx_avail,
	input  wire logic [7:0] tx_data,
	output var  logic       tx_take,
	output var  logic       tx_shift_busy,
	// last character and count taken
	output var  logic [7:0] got,
	output var  logic [7:0] n_got
);
	logic [7:0] cnt;

	assign tx_shift_busy = (cnt != 8'h00);

	// one take per idle shifter; a take never happens without a waiting character
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_take <= 1'b0;
			cnt     <= 8'h00;
			got     <= 8'h00;
			n_got   <= 8'h00;
		end
		else if (tx_take)
		begin
			tx_take <= 1'b0;
			cnt     <= cnt - 8'h01;
		end
		else if (go && !tx_shift_busy && tx_avail)
		begin
			tx_take <= 1'b1;
			got     <= tx_data;
			n_got   <= n_got + 8'h01;
			cnt     <= 8'(HOLD);
		end
		else if (tx_shift_busy)
			cnt <= cnt - 8'h01;
	end
endmodule

`default_nettype wire

// ==== verification/ulsf_core_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port-level checker for the status flags
module ulsf_core_asserts
	import ulsf_pkg::*;
(
	// clock and reset
	input wire logic                   aclk,
	input wire logic                   aresetn,
	// bus
	input wire logic                   awvalid,
	input wire logic                   awready,
	input wire logic [ULSF_ADDR_W-1:0] awaddr,
	input wire logic                   wvalid,
	input wire logic                   wready,
	input wire logic [3:0]             wstrb,
	input wire logic                   bvalid,
	input wire logic                   arvalid,
	input wire logic                   arready,
	input wire logic [ULSF_ADDR_W-1:0] araddr,
	input wire logic                   rvalid,
	input wire logic [31:0]            rdata,
	// line side
	input wire logic                   rx_done,
	input wire logic                   tx_take,
	input wire logic                   tx_avail,
	input wire logic                   irq
);
	logic [3:0] wa_q;
	logic [3:0] ra_q;
	logic       ws_q;
	logic       thre_q;
	logic       seen_q;
	logic       clean_q;
	logic       rdc_q;
	logic       rx_d1;
	logic       rx_d2;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// a character may land up to two edges after its pulse, so a status read
	// only counts as clean when no frame is in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wa_q    <= 4'h0;
			ra_q    <= 4'h0;
			ws_q    <= 1'b0;
			thre_q  <= 1'b1;
			seen_q  <= 1'b0;
			clean_q <= 1'b0;
			rdc_q   <= 1'b0;
			rx_d1   <= 1'b0;
			rx_d2   <= 1'b0;
		end
		else
		begin
			rx_d1 <= rx_done;
			rx_d2 <= rx_d1;
			if (rx_done)
				seen_q <= 1'b1;
			if (awvalid && awready)
				wa_q <= awaddr;
			if (wvalid && wready)
				ws_q <= wstrb[0];
			if (arvalid && arready)
			begin
				ra_q   <= araddr;
				thre_q <= !tx_avail;
				rdc_q  <= clean_q;
			end
			if (rx_done || rx_d1 || rx_d2)
				clean_q <= 1'b0;
			else if (arvalid && arready)
				clean_q <= (araddr == ULSF_OFF_STAT);
		end
	end

	a_irq_when_empty: assert property (irq |-> !tx_avail)
		else $error("irq high while a character waits");
	a_write_fills: assert property ($rose(bvalid) && wa_q == ULSF_OFF_DATA && ws_q
		&& !$past(tx_take) |-> tx_avail && !irq)
		else $error("data write left holding side empty");
	a_avail_cause: assert property ($rose(tx_avail)
		|-> $rose(bvalid) && wa_q == ULSF_OFF_DATA)
		else $error("character appeared without a data write");
	// the response flop is set one edge after both halves are held
	a_b_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_r_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_flags_reset: assert property (rvalid && ra_q == ULSF_OFF_STAT && !seen_q
		|-> rdata[4:2] == 3'h0)
		else $error("receive error flags set with no frame since reset");
	a_read_clears: assert property (rvalid && ra_q == ULSF_OFF_STAT && rdc_q
		|-> rdata[4:2] == 3'h0)
		else $error("receive error flags survived a status read");
	a_thre_read: assert property (rvalid && ra_q == ULSF_OFF_STAT
		|-> rdata[5] == thre_q)
		else $error("holding-empty bit disagrees with waiting character");
	a_temt_thre: assert property (rvalid && ra_q == ULSF_OFF_STAT && rdata[6]
		|-> rdata[5])
		else $error("transmit-empty set while holding side full");
endmodule

bind ulsf_core ulsf_core_asserts chk_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
	.wready, .wstrb, .bvalid, .arvalid, .arready, .araddr, .rvalid, .rdata, .rx_done,
	.tx_take, .tx_avail, .irq);

`default_nettype wire

// ==== verification/tb_uart_line_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin \
	checks_done++; \
	if ((gt) !== (ex)) \
	begin \
		err_count++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, gt); \
	end \
end

// ==========================================================
// register-level bench for the status flags
module tb_uart_line_status_flags import ulsf_pkg::*;;
	logic        aclk = 0, aresetn = 0, go = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        rx_done = 0, rx_par_bit = 0, rx_stop_bit = 1, rx_line = 1;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata;
	logic [7:0]  rx_data = 0, tx_data, got, n_got;
	logic        awready, wready, bvalid, arready, rvalid, tx_take, tx_shift_busy, tx_avail, irq;
	logic [1:0]  bresp, rresp;
	int          err_count = 0, checks_done = 0, cyc = 0;

	always #4 aclk = ~aclk;

	ulsf_core dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .rx_done, .rx_data, .rx_par_bit, .rx_stop_bit, .rx_line, .tx_take,
		.tx_shift_busy, .tx_avail, .tx_data, .irq);
	ulsf_tx_sink sink_u (.aclk, .aresetn, .go, .tx_avail, .tx_data, .tx_take, .tx_shift_busy,
		.got, .n_got);

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_count++;
			test_done();
		end
	end

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ok;
		ok = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
		while (!ok)
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin ok = 1'b1; bready <= 1'b0; `CHK("bresp", er, bresp) end
		end
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [1:0] er,
		input string nm);
		logic ok;
		ok = 1'b0;
		@(posedge aclk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		while (!ok)
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				ok = 1'b1;
				rready <= 1'b0;
				`CHK(nm, ex, rdata)
				`CHK("rresp", er, rresp)
			end
		end
	endtask

	// frame pulses stay high across calls, so frames arrive back to back
	task automatic frame(input logic [7:0] d, input logic p, input logic s, input logic ln);
		@(posedge aclk);
		rx_done <= 1'b1; rx_data <= d; rx_par_bit <= p; rx_stop_bit <= s; rx_line <= ln;
	endtask

	task automatic frames_end;
		@(posedge aclk);
		rx_done <= 1'b0; rx_line <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask

	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ULSF_OFF_STAT, 32'h60, ULSF_RESP_OKAY, "status at reset");
		rd(ULSF_OFF_CTRL, 32'h0, ULSF_RESP_OKAY, "control at reset");
		rd(4'h2, 32'h0, ULSF_RESP_SLV, "unmapped read");
		wr(4'h2, 32'hff, ULSF_RESP_SLV);
		// single register, shifter stalled; the second byte must be dropped
		wr(ULSF_OFF_CTRL, 32'h02, ULSF_RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK("irq empty", 1'b1, irq)
		wr(ULSF_OFF_DATA, 32'h5a, ULSF_RESP_OKAY);
		wr(ULSF_OFF_DATA, 32'h77, ULSF_RESP_OKAY);
		rd(ULSF_OFF_STAT, 32'h00, ULSF_RESP_OKAY, "status holding full");
		`CHK("irq full", 1'b0, irq)
		go <= 1'b1;
		while (tx_avail) @(posedge aclk);
		rd(ULSF_OFF_STAT, 32'h20, ULSF_RESP_OKAY, "status shifting");
		while (tx_shift_busy) @(posedge aclk);
		rd(ULSF_OFF_STAT, 32'h60, ULSF_RESP_OKAY, "status idle");
		`CHK("sent count", 8'h01, n_got)
		`CHK("sent byte", 8'h5a, got)
		// fifo mode, stalled then drained
		go <= 1'b0;
		wr(ULSF_OFF_CTRL, 32'h03, ULSF_RESP_OKAY);
		for (int i = 0; i < 3; i++) wr(ULSF_OFF_DATA, 32'ha1 + i, ULSF_RESP_OKAY);
		rd(ULSF_OFF_STAT, 32'h00, ULSF_RESP_OKAY, "status fifo loaded");
		rd(ULSF_OFF_LEVEL, 32'h03, ULSF_RESP_OKAY, "tx level");
		go <= 1'b1;
		while (tx_avail || tx_shift_busy) @(posedge aclk);
		rd(ULSF_OFF_STAT, 32'h60, ULSF_RESP_OKAY, "status fifo drained");
		`CHK("fifo sent count", 8'h04, n_got)
		`CHK("fifo last byte", 8'ha3, got)
		// fifo receive: parity, framing, then a break held over two frames
		wr(ULSF_OFF_CTRL, 32'h3d, ULSF_RESP_OKAY);
		rd(ULSF_OFF_CTRL, 32'h3d, ULSF_RESP_OKAY, "control readback");
		frame(8'h01, 1'b0, 1'b1, 1'b1);
		frame(8'h03, 1'b0, 1'b0, 1'b1);
		frame(8'h00, 1'b0, 1'b0, 1'b0);
		frame(8'h00, 1'b0, 1'b0, 1'b0);
		frames_end();
		rd(ULSF_OFF_LEVEL, 32'h300, ULSF_RESP_OKAY, "rx level");
		rd(ULSF_OFF_STAT, 32'h65, ULSF_RESP_OKAY, "status parity head");
		rd(ULSF_OFF_STAT, 32'h61, ULSF_RESP_OKAY, "status after clear");
		rd(ULSF_OFF_DATA, 32'h01, ULSF_RESP_OKAY, "rx first");
		rd(ULSF_OFF_STAT, 32'h69, ULSF_RESP_OKAY, "status framing head");
		rd(ULSF_OFF_DATA, 32'h03, ULSF_RESP_OKAY, "rx second");
		// a break frame has no stop bit either, so framing is flagged too
		rd(ULSF_OFF_STAT, 32'h79, ULSF_RESP_OKAY, "status break head");
		rd(ULSF_OFF_DATA, 32'h00, ULSF_RESP_OKAY, "rx break");
		rd(ULSF_OFF_STAT, 32'h60, ULSF_RESP_OKAY, "status one break");
		// single register receive overrun
		wr(ULSF_OFF_CTRL, 32'h30, ULSF_RESP_OKAY);
		frame(8'h11, 1'b0, 1'b1, 1'b1);
		frame(8'h22, 1'b0, 1'b1, 1'b1);
		frames_end();
		rd(ULSF_OFF_STAT, 32'h63, ULSF_RESP_OKAY, "status overrun");
		rd(ULSF_OFF_DATA, 32'h11, ULSF_RESP_OKAY, "rx kept");
		rd(ULSF_OFF_STAT, 32'h60, ULSF_RESP_OKAY, "status drained");
		// odd parity on a 5-bit word: upper data bits are masked off
		wr(ULSF_OFF_CTRL, 32'h04, ULSF_RESP_OKAY);
		frame(8'he1, 1'b0, 1'b1, 1'b1);
		frames_end();
		rd(ULSF_OFF_STAT, 32'h61, ULSF_RESP_OKAY, "status odd parity good");
		rd(ULSF_OFF_DATA, 32'h01, ULSF_RESP_OKAY, "rx short word");
		frame(8'h03, 1'b0, 1'b1, 1'b1);
		frames_end();
		rd(ULSF_OFF_STAT, 32'h65, ULSF_RESP_OKAY, "status odd parity bad");
		test_done();
	end
endmodule

`default_nettype wire
